// >>> tx_link_consts.vh
// Constants for the transmit link-layer control block: register indices,
// field positions, codes, link characters and sequence lengths.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef TX_LINK_CONSTS_VH
`define TX_LINK_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_LINK_TEST      10'h04a
`define IDX_LANE_PACK      10'h04b
`define IDX_LINK_STATUS    10'h060
`define REG_RESET          16'h0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TM_MSB             15
`define TM_LSB             13
`define SYNCREQ_BIT        12
`define ILAE_MSB           11
`define ILAE_LSB           10
`define POLA_BIT           8
`define POLB_BIT           7
`define PACK2_BIT          8
`define CPL_MSB            7
`define CPL_LSB            5

// ----------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------
`define TM_NORMAL          3'h0
`define TM_D215            3'h1
`define TM_K285            3'h2
`define TM_ILA             3'h3
`define TM_PRBS            3'h4
`define CPL_FOUR           3'h0
`define CPL_EIGHT          3'h1
`define CPL_TWO            3'h4

// ----------------------------------------------------------------------
// Link characters and sequence lengths
// ----------------------------------------------------------------------
`define CH_D215            8'hb5
`define CH_K285            8'hbc
`define CH_ILA_START       8'h1c
`define CH_ILA_END         8'h7c
`define CH_ILA_CFG         8'h9c
`define ILA_LAST_MF        2'h3
`define SYNCREQ_LAST       4'h7
`define PRBS_LEN           7'h78
`define PRBS_STEP          7'h08
`define PRBS_PATTERN       120'h81c2_3a1f_6d90_4be5_c7a8_36f1_29d4

`endif

// >>> lane_packer.v
// Packs converter samples into lane words and reports the active lanes.
// Assumes one sample per converter is valid each cycle on its input.
`timescale 1ns/1ps

module lane_packer #(
	parameter SW    = 14,
	parameter NCONV = 16,
	parameter NLANE = 8,
	parameter LW    = 128
) (
	input  wire [NCONV*SW-1:0]  samples,
	input  wire [2:0]           convSel,
	input  wire                 twoOctet,
	output reg  [NLANE*LW-1:0]  laneWord,
	output reg  [NLANE-1:0]     laneMask
);
	`include "tx_link_consts.vh"

	// ------------------------------------------------------------------
	// Converters per lane
	// ------------------------------------------------------------------
	// Codes outside the three legal ones fall back to four per lane.
	function integer convPerLane;
		input [2:0] code;
		begin
			case (code)
				`CPL_EIGHT: convPerLane = 8;
				`CPL_TWO:   convPerLane = 2;
				default:    convPerLane = 4;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Packing
	// ------------------------------------------------------------------
	integer l;
	integer s;
	integer k;
	integer c;
	reg [SW-1:0] smp;
	reg [15:0]   pad;

	always @* begin
		laneWord = {NLANE*LW{1'b0}};
		laneMask = {NLANE{1'b0}};
		smp = {SW{1'b0}};
		pad = 16'h0000;
		k = convPerLane(convSel);
		for (l = 0; l < NLANE; l = l + 1) begin
			laneMask[l] = (l * k < NCONV);
			for (s = 0; s < 8; s = s + 1) begin
				c = l * k + s;
				if (s < k && c < NCONV) begin
					smp = samples[c*SW +: SW];
					pad = 16'h0000;
					pad[15 -: SW] = smp;
					if (twoOctet) begin
						laneWord[l*LW + LW - 16*(s+1) +: 16] = pad;
					end else begin
						laneWord[l*LW + LW - SW*(s+1) +: SW] = smp;
					end
				end
			end
		end
	end
endmodule // lane_packer

// >>> lane_pattern_gen.v
// Alignment sequence and pseudo-random word source, cut from a 120-bit pattern, for all lanes.
// Assumes the caller holds restart high while the sequence must stay at
// its first multiframe.
`timescale 1ns/1ps

module lane_pattern_gen #(
	parameter LW = 128
) (
	input  wire              clk_sys,
	input  wire              rst,
	input  wire              restart,
	input  wire [15:0]       cfgInfo,
	output reg  [LW-1:0]     ilaWord,
	output reg  [LW/8-1:0]   ilaK,
	output wire [1:0]        ilaMf,
	output wire [LW-1:0]     prbsWord
);
	`include "tx_link_consts.vh"

	// ------------------------------------------------------------------
	// Alignment sequence
	// ------------------------------------------------------------------
	reg [1:0] mf_ff;
	reg [6:0] ptr_ff;
	integer   i;

	assign ilaMf = mf_ff;

	always @(posedge clk_sys) begin
		if (rst || restart) begin
			mf_ff <= 2'h0;
		end else begin
			mf_ff <= mf_ff + 2'h1;
		end
	end

	// Each cycle carries one multiframe; the second carries configuration.
	always @* begin
		ilaWord = {LW{1'b0}};
		ilaK = {LW/8{1'b0}};
		for (i = 0; i < LW/8; i = i + 1) begin
			ilaWord[LW-8*(i+1) +: 8] = i[7:0];
		end
		ilaWord[LW-8 +: 8] = `CH_ILA_START;
		ilaK[LW/8-1] = 1'b1;
		ilaWord[7:0] = `CH_ILA_END;
		ilaK[0] = 1'b1;
		if (mf_ff == 2'h1) begin
			ilaWord[LW-16 +: 8] = `CH_ILA_CFG;
			ilaK[LW/8-2] = 1'b1;
			ilaWord[LW-32 +: 16] = cfgInfo;
		end
	end

	// ------------------------------------------------------------------
	// Pseudo-random words
	// ------------------------------------------------------------------
	// The pattern repeats every 120 bits, so each word starts 8 bits on.
	wire [239:0] patTwice = {`PRBS_PATTERN, `PRBS_PATTERN};

	assign prbsWord = patTwice[ptr_ff +: LW];

	always @(posedge clk_sys) begin
		if (rst) begin
			ptr_ff <= 7'h00;
		end else if (ptr_ff + `PRBS_STEP >= `PRBS_LEN) begin
			ptr_ff <= ptr_ff + `PRBS_STEP - `PRBS_LEN;
		end else begin
			ptr_ff <= ptr_ff + `PRBS_STEP;
		end
	end
endmodule // lane_pattern_gen

// >>> jesd_tx_link_layer_control.v
// Transmit link-layer control: APB registers, link state sequence, lane
// pattern selection and phase-reset policy for SYNC~ and SYSREF events.
// Assumes syncN, sysref and lmfcEdge are synchronous to clk_sys.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps

// Overview of operation
// - Pattern code 001 sends D21.5 continuously on all active lanes.
// - Pattern code 010 sends K28.5 comma continuously on all active lanes.
// - Pattern code 011 repeats the alignment sequence endlessly on all active lanes.
// - Pattern code 100 sends a repeating 120-bit pseudo-random pattern.
// - Pattern code 000 is normal data; codes above 100 are invalid.
// - Sync request sends K28.5 stream, then link enters initialization.
// - Two-bit field picks the LMFC edge that starts alignment; default zero.
// - Both policy bits clear: events reset JESD and non-JESD phases.
// - Policy A set: events reset only demodulator and pattern generator.
// - After policy B written one, first event resets all phases.
// - While policy B stays set, later events reset only demodulator, generator.
// - Samples pack densely, or zero-padded to two octets when bit set.
// - Code 000: four converters per lane, four lanes active.
// - Code 001: eight converters per lane, two lanes active.
// - Code 100: two converters per lane, all eight lanes active.
// - Only codes 000, 001 and 100 are legal for converters per lane.
module jesd_tx_link_layer_control #(
	parameter SW    = 14,
	parameter NCONV = 16,
	parameter NLANE = 8,
	parameter LW    = 128
) (
	input  wire                  clk_sys,
	input  wire                  rst,
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [11:0]           paddr,
	input  wire [31:0]           pwdata,
	output reg  [31:0]           prdata,
	output reg                   pready,
	output reg                   pslverr,
	input  wire                  syncN,
	input  wire                  sysref,
	input  wire                  lmfcEdge,
	input  wire [NCONV*SW-1:0]   adcSamples,
	output reg  [NLANE*LW-1:0]   laneData_ff,
	output reg  [NLANE*LW/8-1:0] laneIsK_ff,
	output reg  [NLANE-1:0]      laneActive_ff,
	output reg  [4:0]            linkState_ff,
	output reg                   jesdPhaseReset_ff,
	output reg                   dividerPhaseReset_ff,
	output reg                   demodTpgPhaseReset_ff
);
	`include "tx_link_consts.vh"

	localparam [4:0] ST_SYNCREQ = 5'h01;
	localparam [4:0] ST_CGS     = 5'h02;
	localparam [4:0] ST_WAITE   = 5'h04;
	localparam [4:0] ST_ILA     = 5'h08;
	localparam [4:0] ST_DATA    = 5'h10;

	// Fields are cut from a named word, since a literal cannot be part-selected.
	localparam [15:0] RST_WORD  = `REG_RESET;

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	reg  [2:0] patternSel_ff;
	reg        syncReqBit_ff;
	reg  [1:0] entryEdge_ff;
	reg        policyA_ff;
	reg        policyB_ff;
	reg        twoOctet_ff;
	reg  [2:0] convSel_ff;
	reg        policyArmed_ff;
	reg        syncReqPulse;
	reg        armPulse;

	wire       setup    = psel && !penable;
	wire       wrAccess = psel && penable && pready && pwrite;
	wire [9:0] idx      = paddr[11:2];

	function isMapped;
		input [9:0] a;
		begin
			isMapped = (a == `IDX_LINK_TEST) || (a == `IDX_LANE_PACK)
				|| (a == `IDX_LINK_STATUS);
		end
	endfunction

	wire [15:0] linkTestVal = {patternSel_ff, syncReqBit_ff, entryEdge_ff, 1'b0,
		policyA_ff, policyB_ff, 7'h00};
	wire [15:0] lanePackVal = {7'h00, twoOctet_ff, convSel_ff, 5'h00};
	wire [15:0] statusVal   = {2'h0, policyArmed_ff, linkState_ff, laneActive_ff};

	// Reserved bits are not stored, so they always read back as zero.
	always @(posedge clk_sys) begin
		if (rst) begin
			patternSel_ff <= RST_WORD[`TM_MSB:`TM_LSB];
			syncReqBit_ff <= RST_WORD[`SYNCREQ_BIT];
			entryEdge_ff  <= RST_WORD[`ILAE_MSB:`ILAE_LSB];
			policyA_ff    <= RST_WORD[`POLA_BIT];
			policyB_ff    <= RST_WORD[`POLB_BIT];
			twoOctet_ff   <= RST_WORD[`PACK2_BIT];
			convSel_ff    <= RST_WORD[`CPL_MSB:`CPL_LSB];
			pready        <= 1'b0;
			pslverr       <= 1'b0;
			prdata        <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && (!isMapped(idx) || paddr[1:0] != 2'h0);
			if (setup) begin
				case (idx)
					`IDX_LINK_TEST:   prdata <= {16'h0000, linkTestVal};
					`IDX_LANE_PACK:   prdata <= {16'h0000, lanePackVal};
					`IDX_LINK_STATUS: prdata <= {16'h0000, statusVal};
					default:          prdata <= 32'h0000_0000;
				endcase
			end
			if (wrAccess && paddr[1:0] == 2'h0 && idx == `IDX_LINK_TEST) begin
				patternSel_ff <= pwdata[`TM_MSB:`TM_LSB];
				syncReqBit_ff <= pwdata[`SYNCREQ_BIT];
				entryEdge_ff  <= pwdata[`ILAE_MSB:`ILAE_LSB];
				policyA_ff    <= pwdata[`POLA_BIT];
				policyB_ff    <= pwdata[`POLB_BIT];
			end
			if (wrAccess && paddr[1:0] == 2'h0 && idx == `IDX_LANE_PACK) begin
				twoOctet_ff <= pwdata[`PACK2_BIT];
				convSel_ff  <= pwdata[`CPL_MSB:`CPL_LSB];
			end
		end
	end

	always @* begin
		syncReqPulse = wrAccess && paddr[1:0] == 2'h0 && idx == `IDX_LINK_TEST
			&& pwdata[`SYNCREQ_BIT];
		armPulse = wrAccess && paddr[1:0] == 2'h0 && idx == `IDX_LINK_TEST
			&& pwdata[`POLB_BIT] && !policyB_ff;
	end

	// ------------------------------------------------------------------
	// Phase-reset policy
	// ------------------------------------------------------------------
	reg  syncNPrev_ff;
	reg  sysrefPrev_ff;
	wire phaseEvent = (syncNPrev_ff && !syncN) || (sysref && !sysrefPrev_ff);
	wire fullReset  = (policyB_ff && policyArmed_ff)
		|| (!policyA_ff && !policyB_ff);

	always @(posedge clk_sys) begin
		if (rst) begin
			// A receiver holding sync low at reset release is not a fresh falling edge.
			syncNPrev_ff          <= 1'b0;
			sysrefPrev_ff         <= 1'b0;
			policyArmed_ff        <= 1'b0;
			jesdPhaseReset_ff     <= 1'b0;
			dividerPhaseReset_ff  <= 1'b0;
			demodTpgPhaseReset_ff <= 1'b0;
		end else begin
			syncNPrev_ff  <= syncN;
			sysrefPrev_ff <= sysref;
			// A fresh arming write wins over an event in the same cycle.
			if (armPulse) begin
				policyArmed_ff <= 1'b1;
			end else if (phaseEvent || !policyB_ff) begin
				policyArmed_ff <= 1'b0;
			end
			demodTpgPhaseReset_ff <= phaseEvent;
			jesdPhaseReset_ff     <= phaseEvent && fullReset;
			dividerPhaseReset_ff  <= phaseEvent && fullReset;
		end
	end

	// ------------------------------------------------------------------
	// Link state sequence
	// ------------------------------------------------------------------
	reg  [4:0] nxt_linkState;
	reg  [3:0] reqCnt_ff;
	reg  [1:0] edgeCnt_ff;
	wire [1:0] ilaMf;

	always @* begin
		nxt_linkState = linkState_ff;
		case (linkState_ff)
			ST_SYNCREQ: if (reqCnt_ff == `SYNCREQ_LAST) nxt_linkState = ST_CGS;
			ST_CGS:     if (syncN) nxt_linkState = ST_WAITE;
			ST_WAITE:   if (lmfcEdge && edgeCnt_ff == entryEdge_ff) begin
				nxt_linkState = ST_ILA;
			end
			ST_ILA:     if (ilaMf == `ILA_LAST_MF) nxt_linkState = ST_DATA;
			ST_DATA:    nxt_linkState = ST_DATA;
			default:    nxt_linkState = ST_CGS;
		endcase
		if (!syncN && linkState_ff != ST_SYNCREQ) begin
			nxt_linkState = ST_CGS;
		end
		if (syncReqPulse) begin
			nxt_linkState = ST_SYNCREQ;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			linkState_ff <= ST_CGS;
			reqCnt_ff    <= 4'h0;
			edgeCnt_ff   <= 2'h0;
		end else begin
			linkState_ff <= nxt_linkState;
			reqCnt_ff    <= (nxt_linkState == ST_SYNCREQ && linkState_ff == ST_SYNCREQ
				&& !syncReqPulse) ? reqCnt_ff + 4'h1 : 4'h0;
			if (linkState_ff != ST_WAITE) begin
				edgeCnt_ff <= 2'h0;
			end else if (lmfcEdge) begin
				edgeCnt_ff <= edgeCnt_ff + 2'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Lane sources
	// ------------------------------------------------------------------
	wire [NLANE*LW-1:0] packedWord;
	wire [NLANE-1:0]    packedMask;
	wire [LW-1:0]       ilaWord;
	wire [LW/8-1:0]     ilaK;
	wire [LW-1:0]       prbsWord;
	wire                ilaRestart = (patternSel_ff != `TM_ILA) && (linkState_ff != ST_ILA);

	lane_packer #(
		.SW    (SW),
		.NCONV (NCONV),
		.NLANE (NLANE),
		.LW    (LW)
	) u_packer (
		.samples  (adcSamples),
		.convSel  (convSel_ff),
		.twoOctet (twoOctet_ff),
		.laneWord (packedWord),
		.laneMask (packedMask)
	);

	lane_pattern_gen #(
		.LW (LW)
	) u_patterns (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.restart  (ilaRestart),
		.cfgInfo  (lanePackVal),
		.ilaWord  (ilaWord),
		.ilaK     (ilaK),
		.ilaMf    (ilaMf),
		.prbsWord (prbsWord)
	);

	// ------------------------------------------------------------------
	// Lane output selection
	// ------------------------------------------------------------------
	// The pattern select steers only this mux, useData and ilaRestart, so leaving a test pattern
	// returns to whatever the link sequence is doing, with no new handshake.
	reg [LW-1:0]   selWord;
	reg [LW/8-1:0] selK;

	always @* begin
		selWord = {LW/8{`CH_K285}};
		selK = {LW/8{1'b1}};
		case (patternSel_ff)
			`TM_D215: begin
				selWord = {LW/8{`CH_D215}};
				selK = {LW/8{1'b0}};
			end
			`TM_K285: begin
				selWord = {LW/8{`CH_K285}};
				selK = {LW/8{1'b1}};
			end
			`TM_ILA: begin
				selWord = ilaWord;
				selK = ilaK;
			end
			`TM_PRBS: begin
				selWord = prbsWord;
				selK = {LW/8{1'b0}};
			end
			default: begin
				if (linkState_ff == ST_ILA) begin
					selWord = ilaWord;
					selK = ilaK;
				end else if (linkState_ff == ST_DATA) begin
					selWord = {LW{1'b0}};
					selK = {LW/8{1'b0}};
				end
			end
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < NLANE; g = g + 1) begin : g_lane
			wire useData = (linkState_ff == ST_DATA) && (patternSel_ff == `TM_NORMAL
				|| patternSel_ff > `TM_PRBS);
			always @(posedge clk_sys) begin
				if (rst) begin
					laneData_ff[g*LW +: LW]     <= {LW{1'b0}};
					laneIsK_ff[g*LW/8 +: LW/8]  <= {LW/8{1'b0}};
					laneActive_ff[g]            <= 1'b0;
				end else if (!packedMask[g]) begin
					laneData_ff[g*LW +: LW]     <= {LW{1'b0}};
					laneIsK_ff[g*LW/8 +: LW/8]  <= {LW/8{1'b0}};
					laneActive_ff[g]            <= 1'b0;
				end else begin
					laneData_ff[g*LW +: LW]     <= useData ? packedWord[g*LW +: LW] : selWord;
					laneIsK_ff[g*LW/8 +: LW/8]  <= useData ? {LW/8{1'b0}} : selK;
					laneActive_ff[g]            <= 1'b1;
				end
			end
		end
	endgenerate
endmodule // jesd_tx_link_layer_control

// >>> link_ctrl_asserts.sv
// Concurrent checks on the link control block ports.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`include "tx_link_consts.vh"

module link_ctrl_asserts #(
	parameter NLANE = 8,
	parameter LW    = 128
) (
	input logic                 clk_sys,
	input logic                 rst,
	input logic                 psel,
	input logic                 penable,
	input logic                 pwrite,
	input logic [11:0]          paddr,
	input logic [31:0]          pwdata,
	input logic                 pready,
	input logic                 pslverr,
	input logic                 syncN,
	input logic                 sysref,
	input logic                 lmfcEdge,
	input logic [NLANE*LW-1:0]  laneData_ff,
	input logic [NLANE-1:0]     laneActive_ff,
	input logic [4:0]           linkState_ff,
	input logic                 jesdPhaseReset_ff,
	input logic                 dividerPhaseReset_ff,
	input logic                 demodTpgPhaseReset_ff
);
	// ----
	// Shadow of the control fields, rebuilt from bus writes
	// ----
	wire        acc = psel && penable && pready;
	wire        wrT = acc && pwrite && paddr == {`IDX_LINK_TEST, 2'b00};
	wire        wrP = acc && pwrite && paddr == {`IDX_LANE_PACK, 2'b00};
	wire        mapped = paddr[1:0] == 2'b00 && (paddr[11:2] == `IDX_LINK_TEST
		|| paddr[11:2] == `IDX_LANE_PACK || paddr[11:2] == `IDX_LINK_STATUS);
	logic [2:0] tm_ff, cpl_ff;
	logic [1:0] edgeSel_ff, edgeCnt_ff;
	logic       polA_ff, polB_ff, armed_ff, syncPrev_ff, refPrev_ff;
	wire        ev = (syncPrev_ff && !syncN) || (!refPrev_ff && sysref);
	wire [3:0]  expLanes = cpl_ff == `CPL_EIGHT ? 4'd2 : cpl_ff == `CPL_TWO ? 4'd8 : 4'd4;
	wire        all3 = jesdPhaseReset_ff && dividerPhaseReset_ff && demodTpgPhaseReset_ff;
	wire        only1 = demodTpgPhaseReset_ff && !jesdPhaseReset_ff && !dividerPhaseReset_ff;
	wire        edgeHit = edgeCnt_ff == edgeSel_ff;

	always @(posedge clk_sys) begin
		syncPrev_ff <= syncN;
		refPrev_ff  <= sysref;
		if (rst) begin
			{tm_ff, edgeSel_ff, polA_ff, polB_ff, armed_ff} <= 8'h00;
			{cpl_ff, edgeCnt_ff} <= 5'h00;
		end else begin
			if (wrT) begin
				{tm_ff, edgeSel_ff} <= {pwdata[15:13], pwdata[11:10]};
				{polA_ff, polB_ff} <= pwdata[8:7];
			end
			if (wrP) begin
				cpl_ff <= pwdata[7:5];
			end
			// An arming write wins over an event in the same cycle.
			if (wrT) begin
				armed_ff <= pwdata[7];
			end else if (ev) begin
				armed_ff <= 1'b0;
			end
			if (linkState_ff != 5'h04) begin
				edgeCnt_ff <= 2'h0;
			end else if (lmfcEdge) begin
				edgeCnt_ff <= edgeCnt_ff + 2'h1;
			end
		end
	end

	// ----
	// Assertions
	// ----
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence burstS;
		(linkState_ff == 5'h01) [*8] ##1 linkState_ff == 5'h02;
	endsequence
	property patP(logic [2:0] code, logic [7:0] ch);
		tm_ff == code && linkState_ff == 5'h10 && laneActive_ff[0] && syncN && $past(syncN)
			|=> laneData_ff[127 -: 8] == ch;
	endproperty

	bad_addr_a: assert property (acc |-> pslverr == !mapped)
		else $error("error response does not match the address map");
	d215_a: assert property (patP(`TM_D215, `CH_D215))
		else $error("alternating pattern missing on lane 0");
	k285_a: assert property (patP(`TM_K285, `CH_K285))
		else $error("comma pattern missing on lane 0");
	ila_loop_a: assert property (patP(`TM_ILA, `CH_ILA_START))
		else $error("alignment loop missing its start character");
	sync_burst_a: assert property ($rose(linkState_ff[0]) |-> burstS)
		else $error("sync request burst has wrong length or successor");
	ila_entry_a: assert property (
		linkState_ff == 5'h04 && lmfcEdge && syncN |=>
		linkState_ff == ($past(edgeHit) ? 5'h08 : 5'h04))
		else $error("alignment phase entered on the wrong edge");
	all_reset_a: assert property (ev && !polA_ff && !polB_ff |=> all3)
		else $error("event did not reset every phase");
	pol_a_a: assert property (ev && polA_ff && !armed_ff |=> only1)
		else $error("policy A event reset the wrong phases");
	armed_a: assert property (ev && armed_ff |=> all3)
		else $error("first armed event did not reset every phase");
	later_a: assert property (ev && polB_ff && !armed_ff |=> only1)
		else $error("later policy B event reset the wrong phases");
	lanes_a: assert property (
		1'b1 |=> $countones(laneActive_ff) == $past(expLanes))
		else $error("active lane count does not follow the packing code");
endmodule // link_ctrl_asserts

bind jesd_tx_link_layer_control link_ctrl_asserts #(.NLANE(NLANE), .LW(LW)) chk_u (
	.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.syncN, .sysref, .lmfcEdge, .laneData_ff, .laneActive_ff, .linkState_ff,
	.jesdPhaseReset_ff, .dividerPhaseReset_ff, .demodTpgPhaseReset_ff);

// >>> rx_sync_model.sv
// Receiver model: holds sync low until it has seen enough commas in a row.
// Assumes lane 0 octet 0 and its K flag come straight from the block.
`timescale 1ns/1ps
`include "tx_link_consts.vh"

module rx_sync_model #(
	parameter logic [3:0] KNEED = 4'h4
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [7:0] octet0,
	input  wire logic       octetK,
	output logic            syncN
);
	// ----
	// Comma counter
	// ----
	// A larger KNEED makes the receiver slow to release the link.
	logic [3:0] kCnt_ff;

	always @(posedge clk_sys) begin
		if (rst) begin
			syncN   <= 1'b0;
			kCnt_ff <= 4'h0;
		end else if (!syncN) begin
			if (octetK && octet0 == `CH_K285) begin
				kCnt_ff <= kCnt_ff + 4'h1;
			end else begin
				kCnt_ff <= 4'h0;
			end
			if (kCnt_ff >= KNEED) begin
				syncN <= 1'b1;
			end
		end
	end
endmodule // rx_sync_model

// >>> tb_top.sv
// Testbench for the link control block: APB tasks and directed tests.
// Assumes the receiver model and the bound checker sit beside the block.
`timescale 1ns/1ps
`include "tx_link_consts.vh"

module tb_top;
	logic          clk_sys = 1'b0;
	logic          rst = 1'b1;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [11:0]   paddr = 12'h000;
	logic [31:0]   pwdata = 32'h0;
	logic [31:0]   prdata, rd;
	logic          pready, pslverr, err, syncN;
	logic          sysref = 1'b0;
	logic          lmfcEdge = 1'b0;
	logic [223:0]  adcSamples = {8{14'h1555, 14'h2aaa}};
	logic [1023:0] laneData_ff;
	logic [127:0]  laneIsK_ff, w0;
	logic [7:0]    laneActive_ff;
	logic [4:0]    linkState_ff;
	logic          jesdPhaseReset_ff, dividerPhaseReset_ff, demodTpgPhaseReset_ff;
	logic [2:0]    seen;
	logic [2:0]    lmfcCnt = 3'h0;
	logic [2:0]    cpl [4] = '{3'h0, 3'h1, 3'h4, 3'h2};
	logic [3:0]    nLanes [4] = '{4'd4, 4'd2, 4'd8, 4'd4};
	logic [7:0]    pat [4] = '{8'h00, `CH_D215, `CH_K285, `CH_ILA_START};
	int            errors = 0;
	int            compares = 0;

	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		lmfcCnt  <= lmfcCnt + 3'h1;
		lmfcEdge <= lmfcCnt == 3'h7;
	end

	jesd_tx_link_layer_control dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .syncN, .sysref, .lmfcEdge, .adcSamples,
		.laneData_ff, .laneIsK_ff, .laneActive_ff, .linkState_ff, .jesdPhaseReset_ff,
		.dividerPhaseReset_ff, .demodTpgPhaseReset_ff);
	rx_sync_model rx_u (.clk_sys, .rst, .octet0(laneData_ff[127:120]),
		.octetK(laneIsK_ff[15]), .syncN);

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// The master waits for pready itself; only the watchdog ends a hang.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic waitSt(input logic [4:0] s);
		for (int n = 0; n < 200 && linkState_ff !== s; n++) begin
			@(posedge clk_sys);
		end
	endtask

	task automatic evt(output logic [2:0] s);
		s = 3'h0;
		sysref <= 1'b1;
		repeat (4) begin
			@(posedge clk_sys);
			s = s | {jesdPhaseReset_ff, dividerPhaseReset_ff, demodTpgPhaseReset_ff};
		end
		sysref <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic tally_and_finish;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		tally_and_finish;
	end

	// ----
	// Tests
	// ----
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		apb(1'b0, 12'h12c, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h128, 32'h0800);
		apb(1'b0, 12'h128, 32'h0);
		chk(rd, 32'h0800);
		apb(1'b1, 12'h12a, 32'hffff);
		chk(32'(err), 32'h1);
		apb(1'b0, 12'h1f0, 32'h0);
		chk({rd[31:1], err}, 32'h1);
		waitSt(5'h10);
		chk(32'(linkState_ff), 32'h10);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h12c, {24'h0, cpl[i], 5'h0});
			repeat (3) @(posedge clk_sys);
			chk(32'($countones(laneActive_ff)), 32'(nLanes[i]));
		end
		apb(1'b1, 12'h12c, 32'h080);
		repeat (3) @(posedge clk_sys);
		chk(32'(laneData_ff[127 -: 28]), 32'haaa9555);
		apb(1'b1, 12'h12c, 32'h180);
		repeat (3) @(posedge clk_sys);
		chk(32'(laneData_ff[127 -: 16]), 32'haaa8);
		for (int m = 1; m < 4; m++) begin
			apb(1'b1, 12'h128, (32'(m) << 13) | 32'h0800);
			repeat (3) @(posedge clk_sys);
			chk(32'({laneData_ff[127 -: 8], laneIsK_ff[15]}), 32'({pat[m], m != 1}));
		end
		apb(1'b1, 12'h128, 32'h8800);
		repeat (3) @(posedge clk_sys);
		w0 = laneData_ff[127:0];
		@(posedge clk_sys);
		chk(32'(laneData_ff[127:0] != w0), 32'h1);
		repeat (14) @(posedge clk_sys);
		chk(32'(laneData_ff[127:0] == w0 && laneData_ff[255:128] == w0), 32'h1);
		apb(1'b1, 12'h128, 32'h0800);
		repeat (3) @(posedge clk_sys);
		chk({laneData_ff[127 -: 16], 11'h0, linkState_ff}, 32'haaa80010);
		apb(1'b1, 12'h128, 32'ha800);
		repeat (3) @(posedge clk_sys);
		chk(32'(laneData_ff[127 -: 16]), 32'haaa8);
		apb(1'b1, 12'h128, 32'h1800);
		waitSt(5'h01);
		@(posedge clk_sys);
		chk(32'(laneData_ff[127 -: 8]), 32'(`CH_K285));
		repeat (7) @(posedge clk_sys);
		chk(32'(linkState_ff), 32'h02);
		waitSt(5'h10);
		evt(seen);
		chk(32'(seen), 32'h7);
		apb(1'b1, 12'h128, 32'h0900);
		evt(seen);
		chk(32'(seen), 32'h1);
		apb(1'b1, 12'h128, 32'h0880);
		apb(1'b0, 12'h128, 32'h0);
		chk(rd, 32'h0880);
		apb(1'b0, 12'h180, 32'h0);
		chk(rd, 32'h30ff);
		evt(seen);
		chk(32'(seen), 32'h7);
		evt(seen);
		chk(32'(seen), 32'h1);
		tally_and_finish;
	end
endmodule // tb_top
